/* scpr_defs.vh */
// scpr_defs.vh: constants of the serial configuration memory read block
// assumes inclusion by bare name from the design files
`ifndef SCPR_DEFS_VH
`define SCPR_DEFS_VH

// ----------------------------------------------------------------------------
// geometry and reset values
// ----------------------------------------------------------------------------
`define SCPR_ADDR_W      20
// reset value of every address bit; replicated to the counter width
`define SCPR_ADDR_RST_BIT 1'b0
`define SCPR_FIFO_W      1
`define SCPR_FIFO_DEPTH  8
`define SCPR_FIFO_AW     3
// polarity strap value meaning "reset input active high" (default option)
`define SCPR_POL_ACT_HI  1'b1

`endif

/* scpr_fifo.v */
// scpr_fifo.v: small synchronous FIFO with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module scpr_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);

  // --------------------------------------------------------------------------
  // storage and pointers
  // --------------------------------------------------------------------------
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @* begin
    out_data = mem_q[rd_q];
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= {WIDTH{1'b0}};
      end
    end else if (flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q        <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

/* scpr_reader.v */
// scpr_reader.v: read side of a cascadable one-time-programmable serial
// configuration memory, clocked by the configuring FPGA's clock.
// assumes REF_CLK is the configuration clock and all inputs are synchronous.
`timescale 1ns/10ps
`default_nettype none
`include "scpr_defs.vh"

module scpr_reader #(
  parameter ADDR_W = `SCPR_ADDR_W,
  parameter DEPTH  = `SCPR_FIFO_DEPTH
) (
  input  wire              REF_CLK,
  input  wire              RSTN,
  input  wire              RST_POLARITY_HIGH,
  input  wire              RESET_OE,
  input  wire              CHAIN_SELECT_N,
  output wire              CASCADE_SELECT_OUT_N,
  output wire              DATA_O,
  output wire              DATA_OE,
  output wire              STANDBY,
  output wire [ADDR_W-1:0] MEM_ADDR,
  output wire              MEM_REQ,
  input  wire              MEM_BIT,
  input  wire              MEM_VALID,
  output wire              MEM_READY
);

  // read sequencer states
  localparam [1:0] ST_READ = 2'h0;
  localparam [1:0] ST_DONE = 2'h1;

  // --------------------------------------------------------------------------
  // control decode
  // --------------------------------------------------------------------------
  reg               pol_q;
  reg               pol_seen_q;
  reg  [ADDR_W-1:0] addr_q;
  reg  [ADDR_W-1:0] addr_d;
  reg               past_q;
  reg               past_d;
  reg  [1:0]        st_q;
  reg  [1:0]        st_d;
  reg               dout_q;
  reg               dout_d;
  reg               dval_q;
  reg               dval_d;
  wire              rst_act;
  wire              sel_act;
  wire              advance;
  wire              at_limit;
  wire              fifo_out_v;
  wire              fifo_bit;
  wire              fifo_pop;
  wire              flush;

  // the strap is caught after reset release, never by the async branch
  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pol_q      <= `SCPR_POL_ACT_HI;
      pol_seen_q <= 1'b0;
    end else if (!pol_seen_q) begin
      pol_q      <= RST_POLARITY_HIGH;
      pol_seen_q <= 1'b1;
    end
  end

  assign rst_act  = pol_seen_q ? (RESET_OE == pol_q) : 1'b1;
  assign sel_act  = ~CHAIN_SELECT_N;
  assign at_limit = (addr_q == {ADDR_W{1'b1}});
  assign advance  = sel_act & ~rst_act & ~past_q & dval_q;
  assign flush    = rst_act;

  // --------------------------------------------------------------------------
  // prefetch of stored bits into the FIFO
  // --------------------------------------------------------------------------
  // the memory array is read ahead so, after the first fetch, a bit is ready on each clock
  // edge unless the array answers only every other cycle; the FIFO absorbs array latency and stalls the fetch when full.
  reg  [ADDR_W-1:0] fetch_q;
  reg               fetch_end_q;
  wire              fifo_in_rdy;

  assign MEM_ADDR  = fetch_q;
  assign MEM_REQ   = ~rst_act & ~fetch_end_q;
  assign MEM_READY = fifo_in_rdy & ~rst_act & ~fetch_end_q;

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fetch_q     <= {ADDR_W{`SCPR_ADDR_RST_BIT}};
      fetch_end_q <= 1'b0;
    end else if (rst_act) begin
      // every reset restarts the fetch at address zero with the counter
      fetch_q     <= {ADDR_W{`SCPR_ADDR_RST_BIT}};
      fetch_end_q <= 1'b0;
    end else if (MEM_VALID && MEM_READY) begin
      fetch_q <= fetch_q + 1'b1;
      if (fetch_q == {ADDR_W{1'b1}}) begin
        fetch_end_q <= 1'b1;
      end
    end
  end

  scpr_fifo #(
    .WIDTH (`SCPR_FIFO_W),
    .DEPTH (DEPTH),
    .AW    (`SCPR_FIFO_AW)
  ) u_fifo (
    .clk       (REF_CLK),
    .rst_n     (RSTN),
    .flush     (flush),
    .in_data   (MEM_BIT),
    .in_valid  (MEM_VALID & ~rst_act & ~fetch_end_q),
    .in_ready  (fifo_in_rdy),
    .out_data  (fifo_bit),
    .out_valid (fifo_out_v),
    .out_ready (fifo_pop)
  );

  // the output stage takes a new bit when empty or when the current bit is used
  // only while selected, so a deselected output bit stays frozen
  assign fifo_pop = fifo_out_v & ~past_q & sel_act & (~dval_q | advance);

  // --------------------------------------------------------------------------
  // address counter, output stage and cascade sequencer
  // --------------------------------------------------------------------------
  always @* begin
    addr_d = addr_q;
    past_d = past_q;
    st_d   = st_q;
    dout_d = dout_q;
    dval_d = dval_q;
    if (rst_act) begin
      addr_d = {ADDR_W{`SCPR_ADDR_RST_BIT}};
      past_d = 1'b0;
      st_d   = ST_READ;
      dval_d = 1'b0;
    end else begin
      if (advance) begin
        dval_d = 1'b0;
        if (at_limit) begin
          past_d = 1'b1;
        end else begin
          addr_d = addr_q + 1'b1;
        end
      end
      if (fifo_pop) begin
        dout_d = fifo_bit;
        dval_d = 1'b1;
      end
      // without a reset the counter simply stays where it stopped
      case (st_q)
        ST_READ: begin
          if (advance && at_limit) begin
            st_d = ST_DONE;
          end
        end
        ST_DONE: begin
          st_d = ST_DONE;
        end
        default: begin
          st_d = ST_READ;
        end
      endcase
    end
  end

  always @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      addr_q <= {ADDR_W{`SCPR_ADDR_RST_BIT}};
      past_q <= 1'b0;
      st_q   <= ST_READ;
      dout_q <= 1'b0;
      dval_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      past_q <= past_d;
      st_q   <= st_d;
      dout_q <= dout_d;
      dval_q <= dval_d;
    end
  end

  // --------------------------------------------------------------------------
  // pins
  // --------------------------------------------------------------------------
  // cascade out is combinational from chain select so, after the last bit and outside reset, it tracks it directly
  assign CASCADE_SELECT_OUT_N = ~(sel_act & ~rst_act & past_q);
  assign DATA_O   = dout_q;
  // select low outside reset drives the line until the last bit is out (also when tied low); standby floats it
  assign DATA_OE  = sel_act & ~rst_act & ~past_q;
  assign STANDBY  = ~sel_act;

endmodule

`default_nettype wire

/* scpr_array_model.sv */
// scpr_array_model.sv: stored-bit array behind the reader's fetch port
// assumes the fetch address is meaningful only while req is high
`timescale 1ns/10ps
`default_nettype none

module scpr_array_model #(
  parameter [15:0] CONTENT = 16'hA5C3
) (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [3:0] addr,
  input  wire logic       req,
  output logic            bit_o,
  output logic            valid
);
  logic ph_q = 1'b0;

  always @(posedge clk) ph_q <= ~ph_q;
  // slow array answers every other cycle; idle data is inverted, never held
  assign valid = req & (~slow | ph_q);
  assign bit_o = valid ? CONTENT[addr] : ~CONTENT[addr];
endmodule
`default_nettype wire

/* scpr_reader_assertions.sv */
// scpr_reader_assertions.sv: port-level checker for the serial reader
// assumes a static polarity strap while RSTN is high
`timescale 1ns/10ps
`default_nettype none

module scpr_reader_checker #(
  parameter ADDR_W = 20
) (
  input wire logic              REF_CLK,
  input wire logic              RSTN,
  input wire logic              RST_POLARITY_HIGH,
  input wire logic              RESET_OE,
  input wire logic              CHAIN_SELECT_N,
  input wire logic              CASCADE_SELECT_OUT_N,
  input wire logic              DATA_O,
  input wire logic              DATA_OE,
  input wire logic              STANDBY,
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic              MEM_REQ,
  input wire logic              MEM_BIT,
  input wire logic              MEM_VALID,
  input wire logic              MEM_READY
);
  wire rst_act = (RESET_OE == RST_POLARITY_HIGH);

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  property p_standby; STANDBY == CHAIN_SELECT_N; endproperty
  a_standby: assert property (p_standby) else $error("standby flag wrong");
  property p_sb_float; CHAIN_SELECT_N |-> !DATA_OE; endproperty
  a_sb_float: assert property (p_sb_float) else $error("data driven in standby");
  property p_rst; rst_act |-> !DATA_OE && CASCADE_SELECT_OUT_N; endproperty
  a_rst: assert property (p_rst) else $error("outputs active under reset");
  property p_cause; !CASCADE_SELECT_OUT_N |-> !CHAIN_SELECT_N && !rst_act; endproperty
  a_cause: assert property (p_cause) else $error("cascade low without enables");
  property p_float; !CASCADE_SELECT_OUT_N |-> !DATA_OE; endproperty
  a_float: assert property (p_float) else $error("data driven after last bit");
  property p_follow; !CASCADE_SELECT_OUT_N ##1 !rst_act |-> CASCADE_SELECT_OUT_N == CHAIN_SELECT_N; endproperty
  a_follow: assert property (p_follow) else $error("cascade not following select");
  property p_drive;
    $past(RSTN) && !CHAIN_SELECT_N && !rst_act && CASCADE_SELECT_OUT_N |-> DATA_OE;
  endproperty
  a_drive: assert property (p_drive) else $error("data not driven when selected");
  property p_hold;
    CHAIN_SELECT_N && $past(CHAIN_SELECT_N) && !rst_act && $stable(RESET_OE) |-> $stable(DATA_O);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved in standby");
endmodule

bind scpr_reader scpr_reader_checker #(.ADDR_W(ADDR_W)) u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .RST_POLARITY_HIGH(RST_POLARITY_HIGH), .RESET_OE(RESET_OE),
  .CHAIN_SELECT_N(CHAIN_SELECT_N), .CASCADE_SELECT_OUT_N(CASCADE_SELECT_OUT_N), .DATA_O(DATA_O),
  .DATA_OE(DATA_OE), .STANDBY(STANDBY), .MEM_ADDR(MEM_ADDR), .MEM_REQ(MEM_REQ), .MEM_BIT(MEM_BIT),
  .MEM_VALID(MEM_VALID), .MEM_READY(MEM_READY));
`default_nettype wire

/* scpr_reader_bench.sv */
// scpr_reader_bench.sv: self-checking bench for the serial reader
// assumes a 16-bit array (ADDR_W 4) supplied by scpr_array_model
`timescale 1ns/10ps
`default_nettype none

module scpr_reader_bench;
  localparam [15:0] CONTENT = 16'hA5C3;
  localparam [15:0] CONTENT2 = 16'h0F0F;
  // master serial: all three mode bits of the configuring master low
  logic fpga_mode_select_bit0 = 1'b0, fpga_mode_select_bit1 = 1'b0, fpga_mode_select_bit2 = 1'b0;
  wire d_o2, d_oe2, req2, mbit2, mvalid2;
  wire [3:0] maddr2;
  logic clk = 1'b0, rstn = 1'b0, pol = 1'b1, roe = 1'b1, csn = 1'b1, slow = 1'b0;
  wire cso_n, d_o, d_oe, stby, req, mbit, mvalid, mready;
  wire [3:0] maddr;
  int miscompares = 0, n_compared = 0, cyc = 0, n;
  logic [15:0] got;
  // {reset_oe, chain_select_n, data_oe, cascade_n, standby}
  logic [4:0] rows [0:3] = '{5'h1B, 5'h12, 5'h0B, 5'h06};

  scpr_reader #(.ADDR_W(4)) dut (.REF_CLK(clk), .RSTN(rstn), .RST_POLARITY_HIGH(pol), .RESET_OE(roe),
    .CHAIN_SELECT_N(csn), .CASCADE_SELECT_OUT_N(cso_n), .DATA_O(d_o), .DATA_OE(d_oe), .STANDBY(stby),
    .MEM_ADDR(maddr), .MEM_REQ(req), .MEM_BIT(mbit), .MEM_VALID(mvalid), .MEM_READY(mready));
  scpr_array_model #(.CONTENT(CONTENT)) u_arr (.clk(clk), .slow(slow), .addr(maddr), .req(req),
    .bit_o(mbit), .valid(mvalid));
  // next memory of the chain, selected by the cascade out of the first
  scpr_reader #(.ADDR_W(4)) dut_next (.REF_CLK(clk), .RSTN(rstn), .RST_POLARITY_HIGH(pol), .RESET_OE(roe),
    .CHAIN_SELECT_N(cso_n), .CASCADE_SELECT_OUT_N(), .DATA_O(d_o2), .DATA_OE(d_oe2), .STANDBY(),
    .MEM_ADDR(maddr2), .MEM_REQ(req2), .MEM_BIT(mbit2), .MEM_VALID(mvalid2), .MEM_READY());
  scpr_array_model #(.CONTENT(CONTENT2)) u_arr2 (.clk(clk), .slow(1'b0), .addr(maddr2), .req(req2),
    .bit_o(mbit2), .valid(mvalid2));

  // ---------------------------------------------------------------------------
  // clock, timeout and helpers
  // ---------------------------------------------------------------------------
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end

  task chk(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // inputs always move 5 ns after the rising edge
  task tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task go(input logic p);
    rstn = 1'b0; pol = p; roe = p; csn = 1'b1;
    tick(2);
    rstn = 1'b1;
    tick(2);
  endtask
  // newest bit lands in got[15]; stale lead-in samples fall out the bottom
  task readout;
    if ({fpga_mode_select_bit2, fpga_mode_select_bit1, fpga_mode_select_bit0} != 3'h0) return;
    roe = ~pol; csn = 1'b0; n = 0; got = 16'h0000;
    repeat (200) begin
      tick(1);
      if (d_oe !== 1'b1) break;
      got = {d_o, got[15:1]};
      n++;
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // control truth table, then read-out sequences
  // ---------------------------------------------------------------------------
  initial begin
    go(1'b1);
    foreach (rows[i]) begin
      {roe, csn} = rows[i][4:3];
      tick(1);
      chk(d_oe, rows[i][2]);
      chk(cso_n, rows[i][1]);
      chk(stby, rows[i][0]);
    end
    go(1'b1);
    readout;
    chk(got, CONTENT);
    chk(n >= 16 && n <= 18, 1'b1);
    chk({cso_n, d_oe}, 2'h0);
    chk(d_oe2, 1'b1);
    tick(3);
    chk(cso_n, 1'b0);
    chk(d_o2, CONTENT2[2]);
    csn = 1'b1;
    tick(1);
    chk(cso_n, 1'b1);
    csn = 1'b0;
    tick(1);
    chk({cso_n, d_oe}, 2'h0);
    roe = pol;
    tick(2);
    chk({cso_n, d_oe}, 2'h2);
    readout;
    chk(got, CONTENT);
    go(1'b0);
    csn = 1'b0;
    tick(1);
    chk(d_oe, 1'b0);
    readout;
    chk(got, CONTENT);
    // deselect in mid-stream: the counter freezes and resumes where it stopped
    go(1'b0);
    roe = 1'b1;
    csn = 1'b0;
    tick(6);
    chk(d_o, CONTENT[4]);
    csn = 1'b1;
    tick(4);
    chk({d_oe, d_o}, {1'b0, CONTENT[4]});
    readout;
    chk(got, {CONTENT[15:5], 5'h00});
    chk(n, 11);
    go(1'b0);
    slow = 1'b1;
    readout;
    chk(got[15], CONTENT[15]);
    chk(cso_n, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
